// >>> hw/cmt_pkg.sv
/*
 contents: constants, register offsets and types for the capture match timer
 assumes: included before the timer module; 32-bit classic wishbone
*/
package cmt_pkg;
   localparam logic [7:0] CMT_OFF_CTRL = 8'h00;
   localparam logic [7:0] CMT_OFF_COUNT = 8'h04;
   localparam logic [7:0] CMT_OFF_PRESC = 8'h08;
   localparam logic [7:0] CMT_OFF_PCOUNT = 8'h0C;
   localparam logic [7:0] CMT_OFF_MCTRL = 8'h10;
   localparam logic [7:0] CMT_OFF_CCTRL = 8'h14;
   localparam logic [7:0] CMT_OFF_EMR = 8'h18;
   localparam logic [7:0] CMT_OFF_STAT = 8'h1C;
   localparam logic [7:0] CMT_OFF_MASK = 8'h20;
   localparam logic [7:0] CMT_OFF_MATCH0 = 8'h30;
   localparam logic [7:0] CMT_OFF_MATCH1 = 8'h34;
   localparam logic [7:0] CMT_OFF_MATCH2 = 8'h38;
   localparam logic [7:0] CMT_OFF_MATCH3 = 8'h3C;
   localparam logic [7:0] CMT_OFF_CAP0 = 8'h40;
   localparam logic [7:0] CMT_OFF_CAP1 = 8'h44;
   localparam int CMT_CTRL_EN = 0;
   localparam int CMT_CTRL_CRST = 1;
   localparam int CMT_CTRL_EXT = 2;
   localparam int CMT_CTRL_EXTSEL = 3;
   localparam int CMT_CTRL_EEDGE = 4;
   localparam int CMT_MC_W = 4;
   localparam int CMT_MC_IRQ = 0;
   localparam int CMT_MC_RST = 1;
   localparam int CMT_MC_STOP = 2;
   localparam int CMT_MC_DMA = 3;
   localparam int CMT_CC_W = 3;
   localparam int CMT_CC_RISE = 0;
   localparam int CMT_CC_FALL = 1;
   localparam int CMT_CC_IRQ = 2;
   localparam logic [31:0] CMT_ZERO = 32'h0000_0000;
   localparam logic [31:0] CMT_BAD_READ = 32'hDEAD_0000;
   typedef enum logic [1:0] {EMA_NONE, EMA_LOW, EMA_HIGH, EMA_TOGGLE} cmt_emact_t;
   typedef struct packed {
      logic [31:0] match_v;
      logic [3:0] mode;
      cmt_emact_t act;
   } cmt_match_t;
endpackage : cmt_pkg

// >>> hw/cmt_timer.sv
/*
 contents: 32-bit timer/counter with prescaler, two capture and four match channels
 assumes: single clock, synchronous active-low reset, classic wishbone master
*/
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module cmt_timer
   import cmt_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic [1:0] CAP_IN,
   output logic [3:0] MATCH_OUT,
   output logic [1:0] DMA_REQ_OUT,
   output logic IRQ_OUT
);
   logic [4:0] ctrl_r;
   logic [31:0] count_r, count_nxt;
   logic [31:0] presc_r;
   logic [31:0] pcount_r, pcount_nxt;
   logic [15:0] mctrl_r;
   logic [5:0] cctrl_r;
   logic [7:0] emr_r;
   logic [5:0] stat_r, stat_nxt;
   logic [5:0] mask_r;
   logic [31:0] match_r [0:3];
   logic [31:0] cap_r [0:1];
   logic [2:0] sync_r [0:2];
   logic [3:0] mout_r;
   logic [1:0] dma_r;
   logic [31:0] rdata_r;
   logic ack_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic edge_hit(input logic old_v, input logic new_v,
                                     input logic rise, input logic fall);
      return (rise && !old_v && new_v) || (fall && old_v && !new_v);
   endfunction : edge_hit

   // bus decode
   wire req = WB_CYC_IN && WB_STB_IN && !ack_r;
   wire wr = req && WB_WE_IN;
   wire wr_ctrl = wr && WB_ADR_IN == CMT_OFF_CTRL;
   wire wr_count = wr && WB_ADR_IN == CMT_OFF_COUNT;
   wire wr_presc = wr && WB_ADR_IN == CMT_OFF_PRESC;
   wire wr_pcount = wr && WB_ADR_IN == CMT_OFF_PCOUNT;
   wire wr_mctrl = wr && WB_ADR_IN == CMT_OFF_MCTRL;
   wire wr_cctrl = wr && WB_ADR_IN == CMT_OFF_CCTRL;
   wire wr_emr = wr && WB_ADR_IN == CMT_OFF_EMR;
   wire wr_stat = wr && WB_ADR_IN == CMT_OFF_STAT;
   wire wr_mask = wr && WB_ADR_IN == CMT_OFF_MASK;
   wire [1:0] mslot = WB_ADR_IN[3:2];
   wire wr_match = wr && WB_ADR_IN[7:4] == CMT_OFF_MATCH0[7:4];
   wire [31:0] mctrl_merged = merge({16'h0000, mctrl_r}, WB_DAT_IN, WB_SEL_IN);

   // input synchronisers: bit 0,1 capture, bit 2 external count clock
   wire [2:0] pin_raw = {CAP_IN[ctrl_r[CMT_CTRL_EXTSEL]], CAP_IN};
   wire [2:0] pin_agree = ~(sync_r[1] ^ sync_r[2]);
   logic [2:0] pin_lvl_r;

   wire ext_tick = ctrl_r[CMT_CTRL_EXT] && pin_agree[2] && pin_lvl_r[2] != sync_r[2][2]
                   && (ctrl_r[CMT_CTRL_EEDGE] ? sync_r[2][2] : !sync_r[2][2]);
   wire src_tick = ctrl_r[CMT_CTRL_EXT] ? ext_tick : 1'b1;
   wire running = ctrl_r[CMT_CTRL_EN] && !ctrl_r[CMT_CTRL_CRST];
   wire pre_wrap = running && src_tick && pcount_r >= presc_r;

   logic [3:0] mhit;
   logic [3:0] mreset, mstop;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         mhit[i] = pre_wrap && count_r == match_r[i];
         mreset[i] = mhit[i] && mctrl_r[i*CMT_MC_W + CMT_MC_RST];
         mstop[i] = mhit[i] && mctrl_r[i*CMT_MC_W + CMT_MC_STOP];
      end
   end

   logic [1:0] chit;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         chit[c] = pin_agree[c] && edge_hit(pin_lvl_r[c], sync_r[2][c],
                   cctrl_r[c*CMT_CC_W + CMT_CC_RISE], cctrl_r[c*CMT_CC_W + CMT_CC_FALL]);
      end
   end

   always_comb begin
      count_nxt = count_r;
      pcount_nxt = pcount_r;
      if (ctrl_r[CMT_CTRL_CRST]) begin
         count_nxt = CMT_ZERO;
         pcount_nxt = CMT_ZERO;
      end else if (running && src_tick) begin
         if (pre_wrap) begin
            pcount_nxt = CMT_ZERO;
            count_nxt = (|mreset) ? CMT_ZERO : count_r + 32'h0000_0001;
         end else begin
            pcount_nxt = pcount_r + 32'h0000_0001;
         end
      end
      if (wr_count) begin
         count_nxt = merge(count_r, WB_DAT_IN, WB_SEL_IN);
      end
      if (wr_pcount) begin
         pcount_nxt = merge(pcount_r, WB_DAT_IN, WB_SEL_IN);
      end
   end

   // status: bits 3:0 match, 5:4 capture; set wins over write-one-to-clear
   always_comb begin
      stat_nxt = stat_r;
      if (wr_stat && WB_SEL_IN[0]) begin
         stat_nxt = stat_r & ~WB_DAT_IN[5:0];
      end
      for (int i = 0; i < 4; i++) begin
         if (mhit[i] && mctrl_r[i*CMT_MC_W + CMT_MC_IRQ]) begin
            stat_nxt[i] = 1'b1;
         end
      end
      for (int c = 0; c < 2; c++) begin
         if (chit[c] && cctrl_r[c*CMT_CC_W + CMT_CC_IRQ]) begin
            stat_nxt[4 + c] = 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         for (int k = 0; k < 3; k++) begin
            sync_r[k] <= 3'b000;
         end
         pin_lvl_r <= 3'b000;
      end else begin
         sync_r[0] <= pin_raw;
         sync_r[1] <= sync_r[0];
         sync_r[2] <= sync_r[1];
         for (int k = 0; k < 3; k++) begin
            if (pin_agree[k]) begin
               pin_lvl_r[k] <= sync_r[2][k];
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         count_r <= CMT_ZERO;
         pcount_r <= CMT_ZERO;
         stat_r <= 6'h00;
         ctrl_r <= 5'h00;
      end else begin
         count_r <= count_nxt;
         pcount_r <= pcount_nxt;
         stat_r <= stat_nxt;
         if (wr_ctrl && WB_SEL_IN[0]) begin
            ctrl_r <= WB_DAT_IN[4:0];
         end else if (|mstop) begin
            ctrl_r[CMT_CTRL_EN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         presc_r <= CMT_ZERO;
         mctrl_r <= 16'h0000;
         cctrl_r <= 6'h00;
         emr_r <= 8'h00;
         mask_r <= 6'h00;
         for (int i = 0; i < 4; i++) begin
            match_r[i] <= CMT_ZERO;
         end
      end else begin
         if (wr_presc) presc_r <= merge(presc_r, WB_DAT_IN, WB_SEL_IN);
         if (wr_mctrl) mctrl_r <= mctrl_merged[15:0];
         if (wr_cctrl && WB_SEL_IN[0]) cctrl_r <= WB_DAT_IN[5:0];
         if (wr_emr && WB_SEL_IN[0]) emr_r <= WB_DAT_IN[7:0];
         if (wr_mask && WB_SEL_IN[0]) mask_r <= WB_DAT_IN[5:0];
         if (wr_match) match_r[mslot] <= merge(match_r[mslot], WB_DAT_IN, WB_SEL_IN);
      end
   end

   // captures, match outputs and dma requests
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         cap_r[0] <= CMT_ZERO;
         cap_r[1] <= CMT_ZERO;
         mout_r <= 4'h0;
         dma_r <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (chit[c]) cap_r[c] <= count_r;
         end
         for (int i = 0; i < 4; i++) begin
            if (mhit[i]) begin
               case (cmt_emact_t'(emr_r[i*2 +: 2]))
                  EMA_LOW: mout_r[i] <= 1'b0;
                  EMA_HIGH: mout_r[i] <= 1'b1;
                  EMA_TOGGLE: mout_r[i] <= !mout_r[i];
                  default: mout_r[i] <= mout_r[i];
               endcase
            end
         end
         for (int i = 0; i < 2; i++) begin
            dma_r[i] <= mhit[i] && mctrl_r[i*CMT_MC_W + CMT_MC_DMA];
         end
      end
   end

   // register read and ack
   logic [31:0] rmux;
   always_comb begin
      case (WB_ADR_IN)
         CMT_OFF_CTRL: rmux = {27'h0, ctrl_r};
         CMT_OFF_COUNT: rmux = count_r;
         CMT_OFF_PRESC: rmux = presc_r;
         CMT_OFF_PCOUNT: rmux = pcount_r;
         CMT_OFF_MCTRL: rmux = {16'h0000, mctrl_r};
         CMT_OFF_CCTRL: rmux = {26'h0, cctrl_r};
         CMT_OFF_EMR: rmux = {20'h0, mout_r, emr_r};
         CMT_OFF_STAT: rmux = {26'h0, stat_r};
         CMT_OFF_MASK: rmux = {26'h0, mask_r};
         CMT_OFF_MATCH0, CMT_OFF_MATCH1, CMT_OFF_MATCH2, CMT_OFF_MATCH3: rmux = match_r[mslot];
         CMT_OFF_CAP0: rmux = cap_r[0];
         CMT_OFF_CAP1: rmux = cap_r[1];
         default: rmux = CMT_ZERO;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RSTN_IN) begin
         ack_r <= 1'b0;
         rdata_r <= CMT_ZERO;
      end else begin
         ack_r <= req;
         if (req && !WB_WE_IN) rdata_r <= rmux;
      end
   end

   assign WB_ACK_OUT = ack_r;
   assign WB_DAT_OUT = rdata_r;
   assign MATCH_OUT = mout_r;
   assign DMA_REQ_OUT = dma_r;
   assign IRQ_OUT = |(stat_r & mask_r);

   stop_clears_en_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (|mstop && !wr_ctrl) |=> !ctrl_r[CMT_CTRL_EN])
      else $error("stop on match left counter enabled");
   reset_on_match_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (|mreset && !wr_count && !ctrl_r[CMT_CTRL_CRST]) |=> count_r == CMT_ZERO)
      else $error("reset on match did not zero count");
   capture_value_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      chit[0] |=> cap_r[0] == $past(count_r))
      else $error("capture 0 value wrong");
   irq_level_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (mhit[0] && mctrl_r[CMT_MC_IRQ] && mask_r[0]) |=> IRQ_OUT)
      else $error("match interrupt missing");
   dma_pulse_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      DMA_REQ_OUT[0] |-> $past(mhit[0]))
      else $error("dma request without match");
   count_step_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (pre_wrap && !(|mreset) && !wr_count) |=> count_r == $past(count_r) + 32'h0000_0001)
      else $error("count did not advance");
   hold_between_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (!pre_wrap && !wr_count && !ctrl_r[CMT_CTRL_CRST]) |=> count_r == $past(count_r))
      else $error("count moved without prescale wrap");
   toggle_out_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (mhit[2] && cmt_emact_t'(emr_r[5:4]) == EMA_TOGGLE) |=> MATCH_OUT[2] != $past(MATCH_OUT[2]))
      else $error("toggle action failed");
   dma_one_pulse_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      DMA_REQ_OUT[1] |-> $past(mhit[1]))
      else $error("dma request 1 without match");
   capture_one_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      chit[1] |=> cap_r[1] == $past(count_r))
      else $error("capture 1 value wrong");
   capture_flag_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
      (chit[0] && cctrl_r[CMT_CC_IRQ]) |=> stat_r[4])
      else $error("capture 0 flag not set");
endmodule : cmt_timer

// >>> verif/cmt_pins_model.sv
/*
 contents: pin-side model that drives the two capture inputs
 assumes: the testbench calls its tasks by hierarchical name, one clock
*/
`timescale 1ns/1ps
module cmt_pins_model (
   input wire logic clk_in,
   output logic [1:0] cap_out
);
   initial cap_out = 2'b00;
   // each level is held several cycles so the synchroniser sees it
   task automatic set_lvl(input logic [1:0] v, input int hold);
      @(posedge clk_in);
      cap_out <= v;
      repeat (hold) @(posedge clk_in);
   endtask : set_lvl
   // external count clock on line 0
   task automatic pulses(input int cnt);
      repeat (cnt) begin
         set_lvl(2'b01, 4);
         set_lvl(2'b00, 4);
      end
   endtask : pulses
endmodule : cmt_pins_model

// >>> verif/testbench.sv
/*
 contents: self-checking bench for the capture match timer
 assumes: classic wishbone master here, pin model drives the capture inputs
*/
`timescale 1ns/1ps
module testbench;
   import cmt_pkg::*;
   logic clk, rstn, cyc, stb, we, ack, irq;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q, c0;
   logic [3:0] mtch;
   logic [1:0] dma, cap;
   logic [3:0] sel, lanes;
   int failures, tests_run, n;

   cmt_timer i_dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CAP_IN(cap), .MATCH_OUT(mtch),
      .DMA_REQ_OUT(dma), .IRQ_OUT(irq));
   cmt_pins_model i_pins (.clk_in(clk), .cap_out(cap));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic wrap_up;
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         failures++;
      end
   endtask : chk

   // one classic cycle; byte lanes from lanes, read data lands in q
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= lanes;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 50) begin
         failures++;
         wrap_up();
      end
   endtask : wb

   // cycles until the next request pulse on dma line idx
   task automatic dma_gap(input int idx);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dma[idx] !== 1'b1 && n < 100);
      if (n >= 100) begin
         failures++;
         wrap_up();
      end
   endtask : dma_gap

   // clear count, enable, poll until a stop match drops enable
   task automatic run_once;
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0002);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0001);
      for (int i = 0; i < 20; i++) begin
         wb(1'b0, CMT_OFF_CTRL, CMT_ZERO);
         if (q[0] === 1'b0) break;
      end
      chk(q & 32'h0000_0001, CMT_ZERO);
   endtask : run_once

   task automatic t_reset;
      wb(1'b0, CMT_OFF_CTRL, CMT_ZERO);
      chk(q, CMT_ZERO);
      wb(1'b0, CMT_OFF_COUNT, CMT_ZERO);
      chk(q, CMT_ZERO);
      wb(1'b0, 8'h80, CMT_ZERO);
      chk(q, CMT_ZERO);
      chk({25'h0, mtch, dma, irq}, CMT_ZERO);
      lanes = 4'h2;
      wb(1'b1, CMT_OFF_MATCH0, 32'hAABB_CCDD);
      lanes = 4'hF;
      wb(1'b0, CMT_OFF_MATCH0, CMT_ZERO);
      chk(q, 32'h0000_CC00);
   endtask : t_reset

   task automatic t_period;
      wb(1'b1, CMT_OFF_PRESC, 32'h0000_0001);
      wb(1'b1, CMT_OFF_MATCH0, 32'h0000_0004);
      wb(1'b1, CMT_OFF_MCTRL, 32'h0000_008A);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0002);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0001);
      dma_gap(0);
      dma_gap(0);
      chk(n, 32'h0000_000A);
      dma_gap(1);
      dma_gap(1);
      chk(n, 32'h0000_000A);
      wb(1'b1, CMT_OFF_CTRL, CMT_ZERO);
      wb(1'b0, CMT_OFF_COUNT, CMT_ZERO);
      chk({31'h0, q > 32'h0000_0004}, CMT_ZERO);
      chk({31'h0, dma[1]}, CMT_ZERO);
   endtask : t_period

   task automatic t_emr;
      wb(1'b1, CMT_OFF_PRESC, CMT_ZERO);
      for (int i = 0; i < 4; i++) wb(1'b1, CMT_OFF_MATCH0 + 8'(4 * i), 32'h0000_0002);
      wb(1'b1, CMT_OFF_MCTRL, 32'h0000_0007);
      wb(1'b1, CMT_OFF_MASK, CMT_ZERO);
      wb(1'b1, CMT_OFF_STAT, 32'h0000_003F);
      wb(1'b1, CMT_OFF_EMR, 32'h0000_003A);
      run_once();
      chk({28'h0, mtch}, 32'h0000_0007);
      wb(1'b0, CMT_OFF_STAT, CMT_ZERO);
      chk(q & 32'h0000_0001, 32'h0000_0001);
      chk({31'h0, irq}, CMT_ZERO);
      wb(1'b1, CMT_OFF_MASK, 32'h0000_0001);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0000_0001);
      wb(1'b1, CMT_OFF_STAT, 32'h0000_0001);
      @(negedge clk);
      chk({31'h0, irq}, CMT_ZERO);
      wb(1'b1, CMT_OFF_EMR, 32'h0000_00F1);
      run_once();
      chk({28'h0, mtch}, 32'h0000_000A);
   endtask : t_emr

   task automatic t_capture;
      wb(1'b1, CMT_OFF_MCTRL, CMT_ZERO);
      wb(1'b1, CMT_OFF_CCTRL, 32'h0000_0015);
      wb(1'b1, CMT_OFF_STAT, 32'h0000_003F);
      wb(1'b1, CMT_OFF_MASK, 32'h0000_0010);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0002);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0001);
      i_pins.set_lvl(2'b11, 20);
      i_pins.set_lvl(2'b00, 8);
      wb(1'b1, CMT_OFF_CTRL, CMT_ZERO);
      wb(1'b0, CMT_OFF_CAP0, CMT_ZERO);
      c0 = q;
      wb(1'b0, CMT_OFF_CAP1, CMT_ZERO);
      chk(q - c0, 32'h0000_0015);
      wb(1'b0, CMT_OFF_STAT, CMT_ZERO);
      chk(q & 32'h0000_0030, 32'h0000_0010);
      chk({31'h0, irq}, 32'h0000_0001);
      wb(1'b1, CMT_OFF_CAP0, CMT_ZERO);
      wb(1'b0, CMT_OFF_CAP0, CMT_ZERO);
      chk(q, c0);
   endtask : t_capture

   // rising edges on line 0, then falling edges on line 1
   task automatic t_extcnt;
      wb(1'b1, CMT_OFF_CCTRL, CMT_ZERO);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0002);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0015);
      i_pins.pulses(5);
      i_pins.set_lvl(2'b01, 4);
      wb(1'b1, CMT_OFF_CTRL, CMT_ZERO);
      wb(1'b0, CMT_OFF_COUNT, CMT_ZERO);
      chk(q, 32'h0000_0006);
      i_pins.set_lvl(2'b00, 4);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_0002);
      wb(1'b1, CMT_OFF_CTRL, 32'h0000_000D);
      i_pins.set_lvl(2'b10, 4);
      i_pins.set_lvl(2'b00, 4);
      i_pins.set_lvl(2'b10, 4);
      wb(1'b1, CMT_OFF_CTRL, CMT_ZERO);
      wb(1'b0, CMT_OFF_COUNT, CMT_ZERO);
      chk(q, 32'h0000_0001);
      i_pins.set_lvl(2'b00, 4);
   endtask : t_extcnt

   // reset while match outputs 1 and 3 are high and the timer is stopped clears outputs and registers
   task automatic t_midreset;
      chk({28'h0, mtch}, 32'h0000_000A);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      chk({25'h0, mtch, dma, irq}, CMT_ZERO);
      rstn <= 1'b1;
      wb(1'b0, CMT_OFF_EMR, CMT_ZERO);
      chk(q, CMT_ZERO);
      wb(1'b0, CMT_OFF_COUNT, CMT_ZERO);
      chk(q, CMT_ZERO);
   endtask : t_midreset

   initial begin
      failures = 0;
      tests_run = 0;
      rstn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      lanes = 4'hF;
      wdat = CMT_ZERO;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_period();
      t_emr();
      t_capture();
      t_extcnt();
      t_midreset();
      wrap_up();
   end
endmodule : testbench
